/* rtl/lsio_pkg.sv */
// Package: register map, field layout and operating modes for the LCD-shared I/O ports
package lsio_pkg;

  localparam int unsigned LSIO_AW = 16;
  localparam int unsigned LSIO_DW = 8;

  // Register addresses on the CPU register port
  localparam logic [15:0] LSIO_ADDR_PA_DATA = 16'hFFDA;
  localparam logic [15:0] LSIO_ADDR_PB_DATA = 16'hFFDB;
  localparam logic [15:0] LSIO_ADDR_PA_DIR = 16'hFFEA;
  localparam logic [15:0] LSIO_ADDR_PB_DIR = 16'hFFEB;
  localparam logic [15:0] LSIO_ADDR_PU_CTRL = 16'hFFE3;
  localparam logic [15:0] LSIO_ADDR_LCD_CTRL = 16'hFFC0;

  // Reset values and fixed read values
  localparam logic [7:0] LSIO_RST_DATA = 8'h00;
  localparam logic [7:0] LSIO_RST_DIR = 8'h00;
  localparam logic [7:0] LSIO_RST_PU = 8'h00;
  localparam logic [7:0] LSIO_RST_LCD = 8'h00;
  localparam logic [7:0] LSIO_DIR_READ = 8'hFF;
  localparam logic [7:0] LSIO_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] LSIO_ALL_OUT = 8'hFF;
  localparam logic [7:0] LSIO_ALL_IN = 8'h00;

  // Segment-select field inside the LCD port control register
  localparam int unsigned LSIO_SGS_LSB = 0;
  localparam int unsigned LSIO_SGS_W = 4;
  localparam logic [7:0] LSIO_LCD_MASK = 8'h0F;

  typedef enum logic [2:0] {
    LSIO_MODE_ACTIVE,
    LSIO_MODE_SUBACTIVE,
    LSIO_MODE_SLEEP,
    LSIO_MODE_SUBSLEEP,
    LSIO_MODE_WATCH,
    LSIO_MODE_STANDBY
  } lsio_mode_t;

  // Pins work normally only in the two running modes
  function automatic logic lsio_runs(input lsio_mode_t m);
    lsio_runs = (m == LSIO_MODE_ACTIVE) || (m == LSIO_MODE_SUBACTIVE);
  endfunction : lsio_runs

  function automatic logic lsio_floats(input lsio_mode_t m);
    lsio_floats = (m == LSIO_MODE_STANDBY);
  endfunction : lsio_floats

endpackage : lsio_pkg

/* rtl/lsio_port_pins.sv */
// One 8-pin port: input synchroniser and mode-aware output driver
`timescale 1ns/1ps
`default_nettype none
module lsio_port_pins
  import lsio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire lsio_mode_t op_mode,
  input wire logic seg_owned,
  input wire logic [7:0] data_reg,
  input wire logic [7:0] dir_reg,
  input wire logic [7:0] seg_drive,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_level,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);

  logic [7:0] meta_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] level_q;
  logic [7:0] out_q;
  logic [7:0] oe_q;
  logic [7:0] out_d;
  logic [7:0] oe_d;

  // Three stages; a change is taken only when stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= LSIO_ALL_IN;
      sync2_q <= LSIO_ALL_IN;
      sync3_q <= LSIO_ALL_IN;
    end else begin
      meta_q <= pin_in;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_level
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          level_q[gi] <= 1'b0;
        end else if (sync2_q[gi] == sync3_q[gi]) begin
          level_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    if (seg_owned) begin
      out_d = seg_drive;
      oe_d = LSIO_ALL_OUT;
    end else begin
      out_d = data_reg;
      oe_d = dir_reg;
    end
  end

  // Sleep-type modes freeze the last driven state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= LSIO_ALL_IN;
      oe_q <= LSIO_ALL_IN;
    end else if (lsio_floats(op_mode)) begin
      oe_q <= LSIO_ALL_IN;
    end else if (lsio_runs(op_mode)) begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign pin_level = level_q;
  assign pin_out = out_q;
  assign pin_oe = oe_q;

  a_sync_settle: assert property (@(posedge clk) disable iff (!rstn)
    (sync2_q == sync3_q) |=> (level_q == $past(sync3_q)))
    else $error("settled pin level not taken");

endmodule : lsio_port_pins
`default_nettype wire

/* rtl/lsio_ports.sv */
// Top: register file, read mux, segment routing and pull-up control for the shared ports
// Function
// - Pull-up on only when pin direction is input and its pull-up bit is set.
// - All pull-ups off after reset.
// - Data read returns latched data for bits set as outputs.
// - Data read returns sampled pin level for bits set as inputs.
// - Data registers reset to zero and are readable and writable.
// - Direction 1 drives pin from data bit; direction 0 makes it input.
// - Direction and data act only while segment select gives the pin to I/O.
// - Direction registers reset to zero so pins start as inputs.
// - Direction registers are write-only and read as all ones.
// - Port A is I/O for select 00xx, segment n+17 otherwise.
// - Port B is I/O for select 000x, segment n+25 otherwise.
// - Port A floats in reset and standby, holds in sleep, subsleep and watch, runs otherwise.
// - Port B floats in reset and standby, holds in sleep, subsleep and watch, runs otherwise.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lsio_ports
  import lsio_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire lsio_mode_t op_mode,
  input wire logic [7:0] lcd_drive_output_a,
  input wire logic [7:0] lcd_drive_output_b,
  input wire logic [7:0] port_a_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_pin_oe,
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_pin_oe,
  input wire logic [7:0] pullup_port_direction,
  output logic [7:0] pullup_enable
);

  logic [7:0] port_a_data_q;
  logic [7:0] port_b_data_q;
  logic [7:0] port_a_direction_q;
  logic [7:0] port_b_direction_q;
  logic [7:0] pullup_port_pullup_ctrl_q;
  logic [7:0] lcd_port_control_q;
  logic [7:0] pullup_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] port_a_level;
  logic [7:0] port_b_level;
  logic [LSIO_SGS_W-1:0] segment_select_field;
  logic seg_a_owned;
  logic seg_b_owned;

  assign segment_select_field = lcd_port_control_q[LSIO_SGS_LSB +: LSIO_SGS_W];

  // Segment decode: port A yields at 01xx and up, port B already at 001x
  function automatic logic seg_owns(input logic [3:0] sgs, input logic is_port_b);
    if (is_port_b) begin
      seg_owns = (sgs[3:1] != 3'h0);
    end else begin
      seg_owns = (sgs[3:2] != 2'h0);
    end
  endfunction : seg_owns

  // Read-back of a data register merges latched output bits with pin levels
  function automatic logic [7:0] port_view(input logic [7:0] data, input logic [7:0] dir,
                                           input logic [7:0] level);
    port_view = (data & dir) | (level & ~dir);
  endfunction : port_view

  assign seg_a_owned = seg_owns(segment_select_field, 1'b0);
  assign seg_b_owned = seg_owns(segment_select_field, 1'b1);

  // Data registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_a_data_q <= LSIO_RST_DATA;
      port_b_data_q <= LSIO_RST_DATA;
    end else if (reg_wr) begin
      if (reg_addr == LSIO_ADDR_PA_DATA) begin
        port_a_data_q <= reg_wdata;
      end
      if (reg_addr == LSIO_ADDR_PB_DATA) begin
        port_b_data_q <= reg_wdata;
      end
    end
  end

  // Direction registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_a_direction_q <= LSIO_RST_DIR;
      port_b_direction_q <= LSIO_RST_DIR;
    end else if (reg_wr) begin
      if (reg_addr == LSIO_ADDR_PA_DIR) begin
        port_a_direction_q <= reg_wdata;
      end
      if (reg_addr == LSIO_ADDR_PB_DIR) begin
        port_b_direction_q <= reg_wdata;
      end
    end
  end

  // Pull-up control and LCD port control
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pullup_port_pullup_ctrl_q <= LSIO_RST_PU;
      lcd_port_control_q <= LSIO_RST_LCD;
    end else if (reg_wr) begin
      if (reg_addr == LSIO_ADDR_PU_CTRL) begin
        pullup_port_pullup_ctrl_q <= reg_wdata;
      end
      if (reg_addr == LSIO_ADDR_LCD_CTRL) begin
        lcd_port_control_q <= reg_wdata & LSIO_LCD_MASK;
      end
    end
  end

  // Pull-up enable is registered so the pad control never glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pullup_q <= LSIO_ALL_IN;
    end else begin
      pullup_q <= pullup_port_pullup_ctrl_q & ~pullup_port_direction;
    end
  end

  assign pullup_enable = pullup_q;

  // Read mux; unmapped addresses read as zero
  always_comb begin
    unique case (reg_addr)
      LSIO_ADDR_PA_DATA: rdata_d = port_view(port_a_data_q, port_a_direction_q, port_a_level);
      LSIO_ADDR_PB_DATA: rdata_d = port_view(port_b_data_q, port_b_direction_q, port_b_level);
      LSIO_ADDR_PA_DIR: rdata_d = LSIO_DIR_READ;
      LSIO_ADDR_PB_DIR: rdata_d = LSIO_DIR_READ;
      LSIO_ADDR_PU_CTRL: rdata_d = pullup_port_pullup_ctrl_q;
      LSIO_ADDR_LCD_CTRL: rdata_d = lcd_port_control_q;
      default: rdata_d = LSIO_UNMAPPED_READ;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= LSIO_UNMAPPED_READ;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= LSIO_UNMAPPED_READ;
    end
  end

  assign reg_rdata = rdata_q;

  lsio_port_pins u_port_a (
    .clk(clk),
    .rstn(rstn),
    .op_mode(op_mode),
    .seg_owned(seg_a_owned),
    .data_reg(port_a_data_q),
    .dir_reg(port_a_direction_q),
    .seg_drive(lcd_drive_output_a),
    .pin_in(port_a_pin_in),
    .pin_level(port_a_level),
    .pin_out(port_a_pin_out),
    .pin_oe(port_a_pin_oe)
  );

  lsio_port_pins u_port_b (
    .clk(clk),
    .rstn(rstn),
    .op_mode(op_mode),
    .seg_owned(seg_b_owned),
    .data_reg(port_b_data_q),
    .dir_reg(port_b_direction_q),
    .seg_drive(lcd_drive_output_b),
    .pin_in(port_b_pin_in),
    .pin_level(port_b_level),
    .pin_out(port_b_pin_out),
    .pin_oe(port_b_pin_oe)
  );

  a_pullup_gate: assert property (@(posedge clk) disable iff (!rstn)
    ##1 (pullup_enable == ($past(pullup_port_pullup_ctrl_q) & ~$past(pullup_port_direction))))
    else $error("pull-up enable does not follow direction and control");

  a_dir_reads_ones: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && (reg_addr == LSIO_ADDR_PA_DIR || reg_addr == LSIO_ADDR_PB_DIR))
    |=> (reg_rdata == LSIO_DIR_READ))
    else $error("direction register did not read all ones");

  a_read_out_bits: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == LSIO_ADDR_PA_DATA)
    |=> ((reg_rdata & $past(port_a_direction_q)) ==
         ($past(port_a_data_q) & $past(port_a_direction_q))))
    else $error("output bits did not read latched data");

  a_read_in_bits: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == LSIO_ADDR_PB_DATA)
    |=> ((reg_rdata & ~$past(port_b_direction_q)) ==
         ($past(port_b_level) & ~$past(port_b_direction_q))))
    else $error("input bits did not read pin level");

  a_data_write: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == LSIO_ADDR_PA_DATA) ##1 (reg_rd && reg_addr == LSIO_ADDR_PA_DATA &&
      $past(reg_wdata) == LSIO_ALL_OUT && port_a_direction_q == LSIO_ALL_OUT)
    |=> (reg_rdata == LSIO_ALL_OUT))
    else $error("data register write not read back");

  a_seg_route_a: assert property (@(posedge clk) disable iff (!rstn)
    (lsio_runs(op_mode) && segment_select_field[3:2] != 2'h0)
    |=> (port_a_pin_oe == LSIO_ALL_OUT && port_a_pin_out == $past(lcd_drive_output_a)))
    else $error("port A segment routing wrong");

  a_seg_route_b: assert property (@(posedge clk) disable iff (!rstn)
    (lsio_runs(op_mode) && segment_select_field[3:1] != 3'h0)
    |=> (port_b_pin_oe == LSIO_ALL_OUT && port_b_pin_out == $past(lcd_drive_output_b)))
    else $error("port B segment routing wrong");

  a_gpio_dir: assert property (@(posedge clk) disable iff (!rstn)
    (lsio_runs(op_mode) && segment_select_field[3:2] == 2'h0)
    |=> (port_a_pin_oe == $past(port_a_direction_q) &&
         port_a_pin_out == $past(port_a_data_q)))
    else $error("port A I/O drive does not follow registers");

  a_standby_float: assert property (@(posedge clk) disable iff (!rstn)
    lsio_floats(op_mode) |=> (port_a_pin_oe == LSIO_ALL_IN && port_b_pin_oe == LSIO_ALL_IN))
    else $error("pins driven in standby");

  a_sleep_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!lsio_runs(op_mode) && !lsio_floats(op_mode))
    |=> ($stable(port_a_pin_out) && $stable(port_a_pin_oe) && $stable(port_b_pin_oe)))
    else $error("pins changed in a holding mode");

  a_hold_b: assert property (@(posedge clk) disable iff (!rstn)
    (!lsio_runs(op_mode) && !lsio_floats(op_mode))
    |=> $stable(port_b_pin_out))
    else $error("port B drive value changed in a holding mode");

  a_gpio_dir_b: assert property (@(posedge clk) disable iff (!rstn)
    (lsio_runs(op_mode) && segment_select_field[3:1] == 3'h0)
    |=> (port_b_pin_oe == $past(port_b_direction_q) &&
         port_b_pin_out == $past(port_b_data_q)))
    else $error("port B I/O drive does not follow registers");

  // Mirror of the read checks with the ports swapped, so both merge paths are watched
  a_read_out_b: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == LSIO_ADDR_PB_DATA)
    |=> ((reg_rdata & $past(port_b_direction_q)) ==
         ($past(port_b_data_q) & $past(port_b_direction_q))))
    else $error("port B output bits did not read latched data");

  a_read_in_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == LSIO_ADDR_PA_DATA)
    |=> ((reg_rdata & ~$past(port_a_direction_q)) ==
         ($past(port_a_level) & ~$past(port_a_direction_q))))
    else $error("port A input bits did not read pin level");

  // Read data must fall back to zero so a stale value is never taken as a fresh read
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> (reg_rdata == LSIO_UNMAPPED_READ))
    else $error("read data present without a read strobe");

  a_data_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == LSIO_ADDR_PA_DATA) |=> (port_a_data_q == $past(reg_wdata)))
    else $error("port A data write not stored");

  a_data_store_b: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == LSIO_ADDR_PB_DATA) |=> (port_b_data_q == $past(reg_wdata)))
    else $error("port B data write not stored");

  a_dir_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == LSIO_ADDR_PA_DIR) |=> (port_a_direction_q == $past(reg_wdata)))
    else $error("port A direction write not stored");

  a_dir_store_b: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == LSIO_ADDR_PB_DIR) |=> (port_b_direction_q == $past(reg_wdata)))
    else $error("port B direction write not stored");

  a_pu_ctrl_store: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && reg_addr == LSIO_ADDR_PU_CTRL)
    |=> (pullup_port_pullup_ctrl_q == $past(reg_wdata)))
    else $error("pull-up control write not stored");

  a_pullup_out_off: assert property (@(posedge clk) disable iff (!rstn)
    ##1 ((pullup_enable & $past(pullup_port_direction)) == LSIO_ALL_IN))
    else $error("pull-up on for an output pin");

  a_lcd_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    ((lcd_port_control_q & ~LSIO_LCD_MASK) == '0))
    else $error("unused LCD control bits set");

  // Reset state is checked without a disable so the reset branch itself is covered
  a_reset_values: assert property (@(posedge clk)
    !rstn |=> (pullup_enable == LSIO_RST_PU && port_a_pin_oe == LSIO_ALL_IN &&
      port_b_pin_oe == LSIO_ALL_IN && port_a_data_q == LSIO_RST_DATA &&
      port_b_data_q == LSIO_RST_DATA && port_a_direction_q == LSIO_RST_DIR &&
      port_b_direction_q == LSIO_RST_DIR))
    else $error("register or pin not at its reset value");

endmodule : lsio_ports
`default_nettype wire

/* test/lsio_board.sv */
// Board model: what the circuitry on one 8-pin port presents back to the pin inputs
`timescale 1ns/1ps
`default_nettype none
module lsio_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext,
  input wire logic fight,
  output logic [7:0] pin_in
);
  // A driven pin reads back its own level; with fight set, the board overpowers the driver,
  // so a data read can tell the latched value from the pin level
  assign pin_in = fight ? ext : ((pin_oe & pin_out) | (~pin_oe & ext));
endmodule : lsio_board
`default_nettype wire

/* test/tb.sv */
// Testbench for the LCD-shared I/O ports
`timescale 1ns/1ps
`default_nettype none
module tb
  import lsio_pkg::*;
;
  logic clk, rstn, reg_wr, reg_rd, fight;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, lcd_a, lcd_b, ext_a, ext_b, pin_a, pin_b;
  logic [7:0] out_a, oe_a, out_b, oe_b, pu_dir, pu_en;
  lsio_mode_t op_mode;
  int errors, samples_checked, cyc;

  lsio_board board_a (.pin_out(out_a), .pin_oe(oe_a), .ext(ext_a), .fight(fight), .pin_in(pin_a));
  lsio_board board_b (.pin_out(out_b), .pin_oe(oe_b), .ext(ext_b), .fight(fight), .pin_in(pin_b));

  lsio_ports DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_mode(op_mode),
    .lcd_drive_output_a(lcd_a), .lcd_drive_output_b(lcd_b), .port_a_pin_in(pin_a),
    .port_a_pin_out(out_a), .port_a_pin_oe(oe_a), .port_b_pin_in(pin_b),
    .port_b_pin_out(out_b), .port_b_pin_oe(oe_b), .pullup_port_direction(pu_dir),
    .pullup_enable(pu_en));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run();
    $display("errors %0d, comparisons %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, m);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_reset();
    #1;
    chk(oe_a, 8'h00, "oe a after reset");
    chk(oe_b, 8'h00, "oe b after reset");
    chk(pu_en, 8'h00, "pullups after reset");
    rd(LSIO_ADDR_PA_DATA, 8'h00, "data a reset");
    rd(LSIO_ADDR_PB_DATA, 8'h00, "data b reset");
    rd(LSIO_ADDR_PA_DIR, 8'hFF, "dir a read");
    rd(LSIO_ADDR_PB_DIR, 8'hFF, "dir b read");
    rd(LSIO_ADDR_PU_CTRL, 8'h00, "pullup ctrl reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_data();
    wr(LSIO_ADDR_PA_DIR, 8'hFF);
    // Write then read with no gap between the strobes
    @(posedge clk);
    reg_addr <= LSIO_ADDR_PA_DATA;
    reg_wdata <= 8'hFF;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'hFF, "data a back to back");
    wr(LSIO_ADDR_PA_DATA, 8'hA5);
    wr(LSIO_ADDR_PB_DIR, 8'hFF);
    wr(LSIO_ADDR_PB_DATA, 8'h3C);
    wr(16'hFFD0, 8'h55);
    rd(16'hFFD0, 8'h00, "unmapped read");
    rd(LSIO_ADDR_PA_DATA, 8'hA5, "data a rw");
    rd(LSIO_ADDR_PB_DATA, 8'h3C, "data b rw");
    rd(LSIO_ADDR_PB_DIR, 8'hFF, "dir b after write");
    chk(out_a, 8'hA5, "out a");
    chk(oe_a, 8'hFF, "oe a");
    chk(out_b, 8'h3C, "out b");
    $display("test data done");
  endtask : t_data

  task automatic t_input();
    fight <= 1'b1;
    ext_a <= 8'h3C;
    ext_b <= 8'hC3;
    wr(LSIO_ADDR_PA_DIR, 8'h0F);
    wr(LSIO_ADDR_PB_DIR, 8'hF0);
    settle(5);
    chk(oe_a, 8'h0F, "oe a mixed");
    rd(LSIO_ADDR_PA_DATA, 8'h35, "mixed read a");
    rd(LSIO_ADDR_PB_DATA, 8'h33, "mixed read b");
    fight <= 1'b0;
    $display("test input done");
  endtask : t_input

  task automatic t_pullup();
    @(posedge clk);
    pu_dir <= 8'h3C;
    wr(LSIO_ADDR_PU_CTRL, 8'hF0);
    settle(2);
    chk(pu_en, 8'hC0, "pullup mix");
    rd(LSIO_ADDR_PU_CTRL, 8'hF0, "pullup ctrl read");
    @(posedge clk);
    pu_dir <= 8'hFF;
    settle(2);
    chk(pu_en, 8'h00, "pullup outputs");
    $display("test pullup done");
  endtask : t_pullup

  task automatic t_segment();
    logic [3:0] s;
    logic sa, sb;
    for (int i = 0; i < 16; i++) begin
      s = i[3:0];
      sa = (s[3:2] != 2'b00);
      sb = (s[3:1] != 3'b000);
      wr(LSIO_ADDR_LCD_CTRL, {4'h0, s});
      settle(2);
      chk(oe_a, sa ? 8'hFF : 8'h0F, "seg oe a");
      chk(out_a, sa ? lcd_a : 8'hA5, "seg out a");
      chk(oe_b, sb ? 8'hFF : 8'hF0, "seg oe b");
      chk(out_b, sb ? lcd_b : 8'h3C, "seg out b");
    end
    wr(LSIO_ADDR_LCD_CTRL, 8'h00);
    $display("test segment done");
  endtask : t_segment

  task automatic t_modes();
    lsio_mode_t hold_m[3] = '{LSIO_MODE_SLEEP, LSIO_MODE_SUBSLEEP, LSIO_MODE_WATCH};
    repeat (3) @(posedge clk);
    op_mode <= LSIO_MODE_SLEEP;
    wr(LSIO_ADDR_PA_DATA, 8'h5A);
    wr(LSIO_ADDR_PA_DIR, 8'hF0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      op_mode <= hold_m[i];
      settle(2);
      chk(out_a, 8'hA5, "held out a");
      chk(oe_a, 8'h0F, "held oe a");
      chk(oe_b, 8'hF0, "held oe b");
    end
    @(posedge clk);
    op_mode <= LSIO_MODE_STANDBY;
    settle(2);
    chk(oe_a, 8'h00, "standby a");
    chk(oe_b, 8'h00, "standby b");
    @(posedge clk);
    op_mode <= LSIO_MODE_SUBACTIVE;
    settle(2);
    chk(out_a, 8'h5A, "resume out a");
    chk(oe_a, 8'hF0, "resume oe a");
    $display("test modes done");
  endtask : t_modes

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    fight = 1'b0;
    ext_a = 8'h00;
    ext_b = 8'h00;
    lcd_a = 8'h5A;
    lcd_b = 8'hC3;
    pu_dir = 8'h00;
    op_mode = LSIO_MODE_ACTIVE;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_data();
    t_input();
    t_pullup();
    t_segment();
    t_modes();
    // Second reset in mid-run, taken while pull-ups and registers are away from reset values
    @(posedge clk);
    pu_dir <= 8'h00;
    ext_a <= 8'h00;
    ext_b <= 8'h00;
    settle(2);
    chk(pu_en, 8'hF0, "pullups before reset");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    complete_run();
  end
endmodule : tb
`default_nettype wire
